/* src/reset_flags_and_delay_sequencer.sv */
// reset flag registers, reset release sequencing and clock source choice
// assumes events from supervisors, core and watchdog are one-cycle pulses on clk_i;
// rst_i is the power-on reset of the digital logic itself
`timescale 1ns/1ns
`include "reset_seq_defs.svh"

module reset_flags_and_delay_sequencer #(
  parameter int POR_NS = `POWERON_DELAY_NS,
  parameter int STARTUP_NS = `STARTUP_DELAY_NS,
  parameter int IRST_NS = `INTERNAL_RST_NS,
  parameter int OST_COUNT = `OST_PERIODS,
  parameter int LOCK_CYC = 64
) (
  // clock and power-on reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // supervisor and core events
  input wire logic supply_drop_i,
  input wire logic battery_ok_i,
  input wire logic pin_reset_i,
  input wire logic soft_reset_i,
  input wire logic wdt_timeout_i,
  input wire logic trap_conflict_i,
  input wire logic illegal_op_i,
  input wire logic config_mismatch_i,
  input wire logic watchdog_clear_instr_i,
  input wire logic power_save_instr_i,
  input wire logic power_save_operand_i,
  input wire logic deep_sleep_enable_i,
  // configuration words and clock status
  input wire logic [15:0] config_word_two_i,
  input wire logic [15:0] config_word_three_i,
  input wire logic clock_switch_en_i,
  input wire logic two_speed_en_i,
  input wire logic osc_tick_i,
  // outputs
  output logic system_reset_out_o,
  output logic clock_valid_o,
  output logic use_fast_rc_o,
  output logic [2:0] osc_select_o
);
  import reset_seq_pkg::*;

  localparam int NS_PER_CYC = 1000 / `CLK_MHZ;
  localparam int POR_CYC = (POR_NS + NS_PER_CYC - 1) / NS_PER_CYC;
  localparam int STUP_CYC = (STARTUP_NS + NS_PER_CYC - 1) / NS_PER_CYC;
  localparam int IRST_CYC = (IRST_NS + NS_PER_CYC - 1) / NS_PER_CYC;
  localparam int OST_W = $clog2(OST_COUNT + 1);

  typedef struct packed {
    logic [15:0] ctrl;
    logic [3:0] stat;
    logic [15:0] cal;
    logic [15:0] nvm;
    logic [2:0] cur_osc;
    logic [15:0] dly;
    logic [OST_W-1:0] osc_startup_timer;
    logic [15:0] lock;
    seq_state_t st;
    logic system_reset_out;
    logic clkok;
    logic fastrc;
    logic ack;
    logic [31:0] rdat;
  } state_t;

  state_t s_r, s_nxt;

  function automatic logic [15:0] cyc16(input int n);
    cyc16 = 16'(n < 1 ? 1 : n);
  endfunction

  function automatic logic osc_is_crystal(input logic [2:0] o);
    osc_is_crystal = (o == 3'h2) || (o == 3'h3) || (o == 3'h4);
  endfunction

  logic bor_evt, warm_evt, wr, rd, bus_go;
  logic first_r;
  logic [15:0] wmask, wval;
  logic [2:0] new_osc;

  always_comb
  begin
    s_nxt = s_r;
    bus_go = cyc_i && stb_i && !s_r.ack;
    // a write lands on the edge that sees ack high, not on the taking edge
    wr = cyc_i && stb_i && we_i && s_r.ack;
    rd = bus_go && !we_i;
    wmask = {{8{sel_i[1]}}, {8{sel_i[0]}}};
    wval = dat_i[15:0];
    // brown-out only counts while enabled by config word three
    bor_evt = supply_drop_i && config_word_three_i[`CW3_BROWNOUT_ENABLE_CFG]; // see [R15]
    warm_evt = pin_reset_i || soft_reset_i || wdt_timeout_i || trap_conflict_i
      || illegal_op_i || config_mismatch_i;
    new_osc = s_r.cur_osc;
    // pin, brown-out, or any reset without clock switching restart from config; wdt and soft otherwise keep current
    if (!clock_switch_en_i || bor_evt || pin_reset_i) // see [R16] see [R17]
    begin
      new_osc = config_word_two_i[10:8];
    end
    s_nxt.ack = bus_go;
    s_nxt.rdat = 32'h0;
    // software writes first so that hardware events below take precedence
    if (wr && adr_i == `CTRL_ADDR) // see [R10]
    begin
      s_nxt.ctrl = (s_r.ctrl & ~(wmask & `CTRL_WMASK)) | (wval & wmask & `CTRL_WMASK);
    end
    else if (wr && adr_i == `STAT_ADDR) // see [R05]
    begin
      s_nxt.stat = s_r.stat & ~(~wval[3:0] & wmask[3:0]);
    end
    else if (wr && adr_i == `OSC_ADDR)
    begin
      s_nxt.nvm = (s_r.nvm & ~wmask) | (wval & wmask);
    end
    else if (wr && adr_i == `CAL_ADDR)
    begin
      s_nxt.cal = (s_r.cal & ~wmask) | (wval & wmask);
    end
    if (rd && adr_i == `CTRL_ADDR)
    begin
      s_nxt.rdat = {16'h0, s_r.ctrl};
    end
    else if (rd && adr_i == `STAT_ADDR) // see [R06]
    begin
      s_nxt.rdat = {28'h0, s_r.stat};
    end
    else if (rd && adr_i == `OSC_ADDR)
    begin
      s_nxt.rdat = {s_r.nvm, 1'b0, s_r.cur_osc, 12'h0};
    end
    else if (rd && adr_i == `CAL_ADDR)
    begin
      s_nxt.rdat = {16'h0, s_r.cal};
    end
    // hardware set and clear events, after software so hardware wins
    if (trap_conflict_i) s_nxt.ctrl[`CTRL_TRAP] = 1'b1; // see [R07] see [R24]
    if (illegal_op_i) s_nxt.ctrl[`CTRL_ILLOP] = 1'b1; // see [R07]
    if (config_mismatch_i) s_nxt.ctrl[`CTRL_CMIS] = 1'b1; // see [R07]
    if (pin_reset_i) s_nxt.ctrl[`CTRL_PIN] = 1'b1; // see [R07]
    if (soft_reset_i) s_nxt.ctrl[`CTRL_SOFT] = 1'b1; // see [R07]
    if (watchdog_clear_instr_i || power_save_instr_i)
    begin
      s_nxt.ctrl[`CTRL_WATCHDOG_TIMEOUT_FLAG] = 1'b0; // see [R08]
    end
    if (wdt_timeout_i) s_nxt.ctrl[`CTRL_WATCHDOG_TIMEOUT_FLAG] = 1'b1; // see [R08]
    if (power_save_instr_i && !power_save_operand_i) // see [R09]
    begin
      s_nxt.ctrl[`CTRL_SLEEP] = 1'b1;
      if (deep_sleep_enable_i) s_nxt.ctrl[`CTRL_DSLP] = 1'b1;
    end
    if (power_save_instr_i && power_save_operand_i) s_nxt.ctrl[`CTRL_IDLE] = 1'b1; // see [R09]
    if (!battery_ok_i) s_nxt.stat[`STAT_BPOR] = 1'b1; // see [R03]
    if (first_r && battery_ok_i) s_nxt.stat[`STAT_BRET] = 1'b1; // see [R04]
    if (bor_evt) // see [R01] see [R19]
    begin
      s_nxt.ctrl[`CTRL_BOR] = 1'b1;
      s_nxt.stat[`STAT_VBOR] = 1'b1;
      s_nxt.dly = cyc16(STUP_CYC + IRST_CYC);
    end
    else if (warm_evt) // see [R20]
    begin
      s_nxt.dly = cyc16(IRST_CYC);
    end
    // sequencer: system reset and clock start-up run side by side
    if (bor_evt || warm_evt) // see [R11]
    begin
      s_nxt.st = ST_HOLD;
      s_nxt.system_reset_out = 1'b1;
      s_nxt.clkok = 1'b0;
      s_nxt.cur_osc = new_osc;
      s_nxt.osc_startup_timer = osc_is_crystal(new_osc) ? OST_W'(OST_COUNT) : '0; // see [R21]
      s_nxt.lock = (new_osc == 3'h1 || new_osc == 3'h3) ? cyc16(LOCK_CYC) : 16'h0;
      s_nxt.fastrc = two_speed_en_i; // see [R22]
    end
    else
    begin
      // oscillator timers count concurrently with the reset delay
      if (s_r.osc_startup_timer != '0 && osc_tick_i) s_nxt.osc_startup_timer = s_r.osc_startup_timer - 1'b1; // see [R14] see [R21]
      if (s_r.osc_startup_timer == '0 && s_r.lock != 16'h0) s_nxt.lock = s_r.lock - 16'h1;
      case (s_r.st)
        ST_HOLD:
        begin
          if (s_r.dly <= 16'h1) // see [R13]
          begin
            s_nxt.system_reset_out = 1'b0;
            s_nxt.st = ST_WAIT_CLK;
          end
          else
          begin
            s_nxt.dly = s_r.dly - 16'h1;
          end
        end
        ST_WAIT_CLK:
        begin
          // two-speed: fast rc already good, so core runs while primary starts
          if (s_r.osc_startup_timer == '0 && s_r.lock == 16'h0) // see [R14] see [R22]
          begin
            s_nxt.clkok = 1'b1;
            s_nxt.fastrc = 1'b0;
            s_nxt.st = ST_RUN;
          end
          else if (s_r.fastrc)
          begin
            s_nxt.clkok = 1'b1;
          end
        end
        default:
        begin
          s_nxt.st = ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      // power-on: flags to por values, cal and nvm only cleared here
      s_r <= '0; // see [R12]
      s_r.ctrl <= `CTRL_POR_VAL; // see [R23]
      s_r.stat <= 4'((`STAT_POR_VAL)); // see [R02] see [R04]
      s_r.dly <= cyc16(POR_CYC + STUP_CYC + IRST_CYC); // see [R18]
      s_r.cur_osc <= config_word_two_i[10:8]; // see [R16]
      s_r.osc_startup_timer <= osc_is_crystal(config_word_two_i[10:8]) ? OST_W'(OST_COUNT) : '0;
      s_r.lock <= (config_word_two_i[10:8] == 3'h1 || config_word_two_i[10:8] == 3'h3) ?
        cyc16(LOCK_CYC) : 16'h0;
      s_r.st <= ST_HOLD;
      s_r.system_reset_out <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // battery-return flag, caught on the first edge after power-on reset
  always_ff @(posedge clk_i)
  begin
    first_r <= rst_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dat_o <= 32'h0;
      ack_o <= 1'b0;
      system_reset_out_o <= 1'b1;
      clock_valid_o <= 1'b0;
      use_fast_rc_o <= 1'b0;
      osc_select_o <= 3'h0;
    end
    else
    begin
      dat_o <= s_nxt.rdat;
      ack_o <= s_nxt.ack;
      system_reset_out_o <= s_nxt.system_reset_out;
      clock_valid_o <= s_nxt.clkok;
      use_fast_rc_o <= s_nxt.fastrc;
      osc_select_o <= s_nxt.cur_osc;
    end
  end

  // bus, flag and release checks; each watches the block's own registers
  sequence warm_only_s;
    warm_evt && !bor_evt;
  endsequence

  sequence quiet_s;
    !bor_evt && !warm_evt;
  endsequence

  wb_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack held two cycles");
  ack_resp_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && !ack_o) |=> ack_o)
    else $error("request not answered");
  stat_hi_a: assert property (@(posedge clk_i) disable iff (rst_i) // see [R06]
    (ack_o && !we_i && adr_i == `STAT_ADDR) |-> dat_o[31:4] == 28'h0)
    else $error("status upper bits not zero");
  bor_flag_a: assert property (@(posedge clk_i) disable iff (rst_i) // see [R01]
    bor_evt |=> s_r.stat[`STAT_VBOR] && s_r.ctrl[`CTRL_BOR])
    else $error("brown-out flag not set");
  bor_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // see [R15]
    bor_evt |=> system_reset_out_o)
    else $error("brown-out gave no reset");
  bor_len_a: assert property (@(posedge clk_i) disable iff (rst_i) // see [R19]
    bor_evt |=> s_r.dly == 16'(STUP_CYC + IRST_CYC))
    else $error("brown-out delay wrong");
  trap_set_a: assert property (@(posedge clk_i) disable iff (rst_i) // see [R24]
    trap_conflict_i |=> s_r.ctrl[`CTRL_TRAP])
    else $error("trap flag lost");
  illop_set_a: assert property (@(posedge clk_i) disable iff (rst_i) // see [R07]
    illegal_op_i |=> s_r.ctrl[`CTRL_ILLOP])
    else $error("illegal op flag lost");
  cmis_set_a: assert property (@(posedge clk_i) disable iff (rst_i) // see [R07]
    config_mismatch_i |=> s_r.ctrl[`CTRL_CMIS])
    else $error("mismatch flag lost");
  pin_set_a: assert property (@(posedge clk_i) disable iff (rst_i) // see [R07]
    pin_reset_i |=> s_r.ctrl[`CTRL_PIN])
    else $error("pin flag lost");
  soft_set_a: assert property (@(posedge clk_i) disable iff (rst_i) // see [R07]
    soft_reset_i |=> s_r.ctrl[`CTRL_SOFT])
    else $error("soft flag lost");
  wdt_set_a: assert property (@(posedge clk_i) disable iff (rst_i) // see [R08]
    wdt_timeout_i |=> s_r.ctrl[`CTRL_WATCHDOG_TIMEOUT_FLAG])
    else $error("watchdog flag lost");
  wdt_clr_a: assert property (@(posedge clk_i) disable iff (rst_i) // see [R08]
    ((watchdog_clear_instr_i || power_save_instr_i) && !wdt_timeout_i)
    |=> !s_r.ctrl[`CTRL_WATCHDOG_TIMEOUT_FLAG])
    else $error("watchdog flag not cleared");
  sleep_set_a: assert property (@(posedge clk_i) disable iff (rst_i) // see [R09]
    (power_save_instr_i && !power_save_operand_i)
    |=> s_r.ctrl[`CTRL_SLEEP])
    else $error("sleep flag not set");
  deep_set_a: assert property (@(posedge clk_i) disable iff (rst_i) // see [R09]
    (power_save_instr_i && !power_save_operand_i && deep_sleep_enable_i)
    |=> s_r.ctrl[`CTRL_DSLP])
    else $error("deep sleep flag not set");
  idle_set_a: assert property (@(posedge clk_i) disable iff (rst_i) // see [R09]
    (power_save_instr_i && power_save_operand_i)
    |=> s_r.ctrl[`CTRL_IDLE])
    else $error("idle flag not set");
  bpor_set_a: assert property (@(posedge clk_i) disable iff (rst_i) // see [R03]
    !battery_ok_i |=> s_r.stat[`STAT_BPOR])
    else $error("battery por flag not set");
  bret_set_a: assert property (@(posedge clk_i) disable iff (rst_i) // see [R04]
    (first_r && battery_ok_i) |=> s_r.stat[`STAT_BRET])
    else $error("battery return flag not set");
  stat_clr_a: assert property (@(posedge clk_i) disable iff (rst_i) // see [R05]
    !supply_drop_i |=> !($rose(s_r.stat[`STAT_VPOR])))
    else $error("por flag set by sw");
  warm_dly_a: assert property (@(posedge clk_i) disable iff (rst_i) // see [R20]
    warm_only_s ##1 quiet_s[*2] |-> system_reset_out_o)
    else $error("reset released too early");
  warm_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // see [R13]
    warm_only_s |=> system_reset_out_o)
    else $error("warm reset not held");
  osc_fixed_a: assert property (@(posedge clk_i) disable iff (rst_i) // see [R17]
    ((warm_evt || bor_evt) && !clock_switch_en_i)
    |=> osc_select_o == $past(config_word_two_i[10:8]))
    else $error("osc not from config");
  osc_keep_a: assert property (@(posedge clk_i) disable iff (rst_i) // see [R16]
    ((soft_reset_i || wdt_timeout_i) && clock_switch_en_i && !pin_reset_i && !bor_evt)
    |=> osc_select_o == $past(s_r.cur_osc))
    else $error("current osc not kept");
  cal_keep_a: assert property (@(posedge clk_i) disable iff (rst_i) // see [R12]
    ((warm_evt || bor_evt) && !(wr && adr_i == `CAL_ADDR))
    |=> s_r.cal == $past(s_r.cal))
    else $error("calibration lost on reset");
  nvm_keep_a: assert property (@(posedge clk_i) disable iff (rst_i) // see [R12]
    ((warm_evt || bor_evt) && !(wr && adr_i == `OSC_ADDR))
    |=> s_r.nvm == $past(s_r.nvm))
    else $error("nvm control lost on reset");
  fast_rc_a: assert property (@(posedge clk_i) disable iff (rst_i) // see [R22]
    (warm_evt || bor_evt) |=> use_fast_rc_o == $past(two_speed_en_i))
    else $error("fast rc choice wrong");
  ctrl_rsv_a: assert property (@(posedge clk_i) disable iff (rst_i) // see [R10]
    (s_r.ctrl & ~`CTRL_WMASK) == 16'h0)
    else $error("unimplemented control bit set");
  rel_seq_a: assert property (@(posedge clk_i) disable iff (rst_i) // see [R14]
    $fell(system_reset_out_o) |-> !clock_valid_o || s_r.fastrc || s_r.osc_startup_timer == '0)
    else $error("clock valid before start-up");
  clk_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // see [R14]
    system_reset_out_o |-> !clock_valid_o)
    else $error("clock valid during reset");
endmodule

/* src/reset_seq_defs.svh */
// register offsets, field positions, reset values and timing for the reset sequencer
// assumes a 100 MHz system clock and a 32-bit classic wishbone slave port
// Summary of operation
// [R01] hardware sets supply brown-out flag bit 3
// [R02] hardware sets supply power-on flag bit 2
// [R03] battery por flag set: no battery, first power-up
// [R04] battery-return flag bit 0 set on por exit
// [R05] supply/battery flags: software clears only
// [R06] status bits 15:5 read zero, bit 4 reserved
// [R07] trap, illegal, mismatch, pin, soft flags cleared by por
// [R08] watchdog flag cleared by watchdog_clear_instr, power-save, por
// [R09] power-save sets sleep, idle, deep-sleep flags
// [R10] software sets/clears reset flags without reset
// [R11] only control and osc regs depend on type
// [R12] calibration and nvm regs reset only by por
// [R13] release system reset after type delay expires
// [R14] osc start-up runs concurrently; run needs clock
// [R15] brown-out enable config lets supply drop reset
// [R16] por/bor/pin use config osc; wdt/sw keep current
// [R17] no clock switching: always config osc select
// [R18] por delay is poweron plus startup plus internal
// [R19] bor delay is startup plus internal reset
// [R20] other resets use internal reset time only
// [R21] crystal: 1024-period start-up count, pll adds lock
// [R22] two-speed start-up runs fast rc then primary; code does this only on bor and warm resets, fastrc stays 0 after por
// [R23] por clears control flags, sets bits 1:0
// [R24] hardware set wins over software clear
`ifndef RESET_SEQ_DEFS_SVH
`define RESET_SEQ_DEFS_SVH

`define CTRL_ADDR 4'h0
`define STAT_ADDR 4'h4
`define OSC_ADDR 4'h8
`define CAL_ADDR 4'hc

`define CTRL_TRAP 15
`define CTRL_ILLOP 14
`define CTRL_DSLP 10
`define CTRL_CMIS 9
`define CTRL_FBIAS 8
`define CTRL_PIN 7
`define CTRL_SOFT 6
`define CTRL_WATCHDOG_TIMEOUT_FLAG 4
`define CTRL_SLEEP 3
`define CTRL_IDLE 2
`define CTRL_BOR 1
`define CTRL_POR 0
`define CTRL_WMASK 16'hc7df
`define CTRL_POR_VAL 16'h0003

`define STAT_VBOR 3
`define STAT_VPOR 2
`define STAT_BPOR 1
`define STAT_BRET 0
`define STAT_POR_VAL 16'h000e

`define CW3_BROWNOUT_ENABLE_CFG 12
`define OSC_CUR_HI 14
`define OSC_CUR_LO 12

`define CLK_MHZ 100
`define POWERON_DELAY_NS 10000
`define STARTUP_DELAY_NS 10000
`define INTERNAL_RST_NS 2000
`define OST_PERIODS 1024

`endif

/* src/reset_seq_pkg.sv */
// types shared by the reset sequencer
// assumes nothing beyond the defs header
package reset_seq_pkg;
  typedef enum logic [1:0] {
    RT_POR = 2'b00,
    RT_BOR = 2'b01,
    RT_WARM = 2'b11
  } rst_type_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_HOLD = 2'b01,
    ST_WAIT_CLK = 2'b11
  } seq_state_t;
endpackage

/* verification/event_source.sv */
// stand-in for core, watchdog and supervisors: event pulses and oscillator ticks
// assumes the bench calls fire() with an event code and owns every level input
`timescale 1ns/1ns
module event_source (
  // clock
  input wire logic clk_i,
  // events and oscillator
  output logic [8:0] ev_o,
  output logic osc_tick_o
);
  logic [1:0] div_r;
  initial
  begin
    ev_o = '0;
    div_r = '0;
  end
  // oscillator slower than the core clock so the start-up count takes real time
  always @(posedge clk_i)
  begin
    div_r <= (div_r == 2'h2) ? 2'h0 : div_r + 2'h1;
  end
  assign osc_tick_o = (div_r == 2'h0);
  // one-cycle pulse: the block reacts to the event, not to a held level
  task automatic fire(input int c);
    @(posedge clk_i);
    ev_o <= 9'h1 << c;
    @(posedge clk_i);
    ev_o <= '0;
  endtask
endmodule

/* verification/reset_flags_and_delay_sequencer_tb.sv */
// bench for the reset sequencer: flags over the bus, reset release, clock choice
// assumes shortened delay parameters and the event source stand-in
`timescale 1ns/1ns
`include "reset_seq_defs.svh"
module reset_flags_and_delay_sequencer_tb;
  import reset_seq_pkg::*;
  localparam int POR_CYC = 22;
  localparam int BOR_CYC = 12;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, bat, opnd, dse, csw, srst, cval, fast_rc_osc, tick;
  logic [3:0] adr_i, sel_i, sel;
  logic tsp;
  logic [31:0] dat_i, dat_o;
  logic [15:0] cw2, cw3, rd, v;
  logic [8:0] ev;
  logic [2:0] osc;
  int mismatches, tests_run, n, i;
  int codes [6] = '{1, 2, 4, 5, 6, 3};
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  reset_flags_and_delay_sequencer #(.POR_NS(100), .STARTUP_NS(100), .IRST_NS(20),
    .OST_COUNT(4), .LOCK_CYC(2)) dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .supply_drop_i(ev[0]), .battery_ok_i(bat), .pin_reset_i(ev[1]),
    .soft_reset_i(ev[2]), .wdt_timeout_i(ev[3]), .trap_conflict_i(ev[4]),
    .illegal_op_i(ev[5]), .config_mismatch_i(ev[6]), .watchdog_clear_instr_i(ev[7]),
    .power_save_instr_i(ev[8]), .power_save_operand_i(opnd), .deep_sleep_enable_i(dse),
    .config_word_two_i(cw2), .config_word_three_i(cw3), .clock_switch_en_i(csw),
    .two_speed_en_i(tsp), .osc_tick_i(tick), .system_reset_out_o(srst),
    .clock_valid_o(cval), .use_fast_rc_o(fast_rc_osc), .osc_select_o(osc));
  event_source core (.clk_i(clk_i), .ev_o(ev), .osc_tick_o(tick));
  function automatic logic [15:0] flag_of(input int c);
    case (c)
      1: return 16'h1 << `CTRL_PIN;
      2: return 16'h1 << `CTRL_SOFT;
      3: return 16'h1 << `CTRL_WATCHDOG_TIMEOUT_FLAG;
      4: return 16'h1 << `CTRL_TRAP;
      5: return 16'h1 << `CTRL_ILLOP;
      default: return 16'h1 << `CTRL_CMIS;
    endcase
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // classic cycle: hold everything until ack is sampled, then drop for a cycle
  task automatic wb(input logic w, input logic [3:0] a, input logic [15:0] d,
    output logic [15:0] q);
    int k;
    k = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'h3, w, a, sel, 16'($urandom), d};
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (ack_o !== 1'b1 && k < 50);
    chk("ack", {15'h0, ack_o}, 16'h1);
    q = dat_o[15:0];
    {cyc_i, stb_i, we_i} <= 3'h0;
  endtask
  // cycles until the system reset lets go, then until a clock is handed over
  task automatic rel(output int m);
    int k;
    m = 0;
    k = 0;
    do
    begin
      @(posedge clk_i);
      m++;
    end
    while (srst !== 1'b0 && m < 500);
    while (cval !== 1'b1 && k < 100)
    begin
      @(posedge clk_i);
      k++;
    end
    chk("clock valid", {15'h0, cval}, 16'h1);
  endtask
  task automatic por();
    rst_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rel(n);
    chk("por delay", 16'(n >= POR_CYC - 1 && n <= POR_CYC + 3), 16'h1);
  endtask
  initial
  begin
    {cyc_i, stb_i, we_i, bat, opnd, dse, csw, rst_i} = 8'h1;
    {adr_i, sel_i, dat_i, cw2, cw3} = '0;
    {tsp, sel} = 5'h3;
    mismatches = 0;
    tests_run = 0;
    void'($urandom(32'hda644c2f));
    por();
    wb(0, `CTRL_ADDR, 16'h0, rd);
    chk("ctrl after por", rd, `CTRL_POR_VAL);
    wb(0, `STAT_ADDR, 16'h0, rd);
    chk("status after por", rd, `STAT_POR_VAL);
    bat <= 1'b1;
    wb(1, `STAT_ADDR, 16'h0, rd);
    wb(1, `STAT_ADDR, 16'hffef, rd);
    wb(0, `STAT_ADDR, 16'h0, rd);
    chk("status no sw set", rd, 16'h0);
    wb(0, 4'h6, 16'h0, rd);
    chk("unmapped", rd, 16'h0);
    v = 16'($urandom) & `CTRL_WMASK;
    wb(1, `CTRL_ADDR, v, rd);
    wb(0, `CTRL_ADDR, 16'h0, rd);
    chk("sw set flags", rd, v);
    chk("no reset from sw", {15'h0, srst}, 16'h0);
    for (i = 0; i < 6; i++)
    begin
      wb(1, `CTRL_ADDR, 16'h0, rd);
      core.fire(codes[i]);
      rel(n);
      chk("warm delay", 16'(n <= 6), 16'h1);
      wb(0, `CTRL_ADDR, 16'h0, rd);
      chk("event flag", rd, flag_of(codes[i]));
    end
    core.fire(7);
    wb(0, `CTRL_ADDR, 16'h0, rd);
    chk("wdt clear", rd, 16'h0);
    core.fire(3);
    rel(n);
    dse <= 1'b1;
    core.fire(8);
    wb(0, `CTRL_ADDR, 16'h0, rd);
    chk("sleep deep", rd, 16'h0408);
    {dse, opnd} <= 2'h1;
    core.fire(8);
    wb(0, `CTRL_ADDR, 16'h0, rd);
    chk("idle", rd, 16'h040c);
    wb(1, `CTRL_ADDR, 16'h0, rd);
    core.fire(0);
    repeat (4) @(posedge clk_i);
    chk("bor disabled", {15'h0, srst}, 16'h0);
    cw3 <= 16'h1 << `CW3_BROWNOUT_ENABLE_CFG;
    core.fire(0);
    rel(n);
    chk("bor delay", 16'(n >= BOR_CYC - 1 && n <= BOR_CYC + 3), 16'h1);
    wb(0, `CTRL_ADDR, 16'h0, rd);
    chk("bor ctrl", rd, 16'h0002);
    wb(0, `STAT_ADDR, 16'h0, rd);
    chk("bor status", rd, 16'h0008);
    {tsp, csw, cw2} <= {2'h3, 16'h0200};
    core.fire(1);
    rel(n);
    chk("fast rc first", {15'h0, fast_rc_osc}, 16'h1);
    repeat (30) @(posedge clk_i);
    chk("primary after", {15'h0, fast_rc_osc}, 16'h0);
    tsp <= 1'b0;
    v = 16'($urandom % 8);
    {csw, cw2} <= {1'b1, 5'h0, v[2:0], 8'h0};
    core.fire(1);
    rel(n);
    chk("osc pin", {13'h0, osc}, v);
    cw2 <= {5'h0, ~v[2:0], 8'h0};
    core.fire(2);
    rel(n);
    chk("osc soft keeps", {13'h0, osc}, v);
    csw <= 1'b0;
    core.fire(3);
    rel(n);
    chk("osc no switch", {13'h0, osc}, {13'h0, ~v[2:0]});
    v = 16'($urandom);
    wb(1, `CAL_ADDR, v, rd);
    core.fire(2);
    rel(n);
    wb(0, `CAL_ADDR, 16'h0, rd);
    chk("cal kept", rd, v);
    sel <= 4'h1;
    wb(1, `CAL_ADDR, v ^ 16'h5aa5, rd);
    sel <= 4'h3;
    wb(0, `CAL_ADDR, 16'h0, rd);
    chk("cal low lane", rd, {v[15:8], v[7:0] ^ 8'ha5});
    por();
    wb(0, `CTRL_ADDR, 16'h0, rd);
    chk("ctrl second por", rd, `CTRL_POR_VAL);
    wb(0, `STAT_ADDR, 16'h0, rd);
    chk("status battery", rd, `STAT_POR_VAL | 16'h1);
    test_done();
  end
  initial
  begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    test_done();
  end
endmodule
